// *** core/srr_pkg.sv ***
// constants and types of the system reset and recovery counter block
// Function
// [R1] halt instruction with halt disabled raises an illegal opcode reset
// [R2] opcode fetch from unmapped space sets the address flag and resets
// [R3] data read from unmapped space causes no reset
// [R4] reset vector bytes reading all ones raise an erased vector reset
// [R5] after an erased vector reset the device starts in monitor mode
// [R6] low voltage sets its flag and resets unless either disable bit set
// [R7] reset held while low voltage stays asserted; counting starts after
// [R8] after low voltage clears count 4096 cycles, then 64 before release
// [R9] recovery counter is 12 bits, steps on oscillator falling edges
// [R10] each counter overflow gives the watchdog its clock pulse
// [R11] power-on and halt recovery keep bus clocks off until stable
// [R12] the halt instruction clears the recovery counter
// [R13] leaving halt samples short recovery: 32 cycles, otherwise 4096
// [R14] after every reset state the counter runs freely
// [R15] power-on request initialises, then enables the clock generator
// [R16] internal bus clock runs at half the clock generator rate
// [R17] internal reset asserted while any source active, until count done
package srr_pkg;

    // ********************************************************
    // widths and pin indices
    // ********************************************************
    localparam int CNT_W   = 12;
    localparam int SYNC_W  = 5;
    localparam int PIN_OSC = 0;
    localparam int PIN_CGO = 1;
    localparam int PIN_POR = 2;
    localparam int PIN_LVD = 3;
    localparam int PIN_WAK = 4;

    // ********************************************************
    // recovery counts in oscillator cycles
    // ********************************************************
    localparam int LV_RECOVERY_CYC  = 4096;
    localparam int VECTOR_DELAY_CYC = 64;
    localparam int HALT_SHORT_CYC   = 32;
    localparam int HALT_NORMAL_CYC  = 4096;

    localparam logic [CNT_W-1:0] STAB_LAST   = CNT_W'(LV_RECOVERY_CYC - 1);
    localparam logic [CNT_W-1:0] VECTOR_LAST = CNT_W'(VECTOR_DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] HSHORT_LAST = CNT_W'(HALT_SHORT_CYC - 1);
    localparam logic [CNT_W-1:0] HNORM_LAST  = CNT_W'(HALT_NORMAL_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO    = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE     = 12'h001;
    localparam logic [CNT_W-1:0] CNT_MAX     = 12'hfff;
    localparam logic [7:0]       ERASED_BYTE = 8'hff;

    // ********************************************************
    // carriers
    // ********************************************************
    typedef struct packed {
        logic halt_enable;
        logic lv_monitor_power_disable;
        logic lv_reset_disable;
        logic short_recovery_select;
    } srr_option_register_one_t;

    typedef struct packed {
        logic       valid;
        logic       opcode_fetch;
        logic       unmapped;
        logic       halt_instr;
        logic       vector_fetch;
        logic [7:0] data;
    } srr_bus_cycle_t;

    typedef struct packed {
        logic por;
        logic illegal_opcode;
        logic illegal_address_flag;
        logic erased_vector_reset;
        logic low_voltage;
    } srr_reset_status_reg_t;

    localparam srr_reset_status_reg_t STATUS_POR_VALUE = 5'h10;
    localparam srr_reset_status_reg_t STATUS_ZERO      = 5'h00;

    typedef enum {
        ST_HOLD,
        ST_STAB,
        ST_VECTOR,
        ST_RUN,
        ST_HALT,
        ST_HALT_REC
    } srr_state_t;

endpackage

// *** core/srr_sync.sv ***
// two-flop synchroniser, one per pin
module srr_sync
    import srr_pkg::*;
#(
    parameter int WIDTH = SYNC_W
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_b,
    // pins
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
                // power-on pin reads asserted in reset, no false enable
                if (!i_rst_b) begin
                    meta_q[g] <= 1'(g == PIN_POR);
                    sync_q[g] <= 1'(g == PIN_POR);
                end else begin
                    meta_q[g] <= i_async[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_q;

endmodule

// *** core/srr_counter.sv ***
// 12-bit recovery counter with clear and overflow pulse
module srr_counter
    import srr_pkg::*;
(
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_b,
    // control
    input  wire logic             i_clear,
    input  wire logic             i_step,
    // state
    output logic      [CNT_W-1:0] o_count,
    output logic                  o_wrap
);

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= CNT_ZERO;
        end else if (i_clear) begin
            cnt_q <= CNT_ZERO;
        end else if (i_step) begin
            cnt_q <= cnt_q + CNT_ONE; // [R9]
        end
    end

    // overflow is the step out of the top value
    assign o_wrap  = i_step && !i_clear && (cnt_q == CNT_MAX); // [R10]
    assign o_count = cnt_q;

endmodule

// *** core/srr_top.sv ***
// reset source handling and recovery sequencing of the integration unit
module srr_top
    import srr_pkg::*;
(
    // clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst_b,
    // pins from clock generator and detectors
    input  wire logic                     i_selected_osc_clock,
    input  wire logic                     i_clock_gen_output,
    input  wire logic                     i_power_on_reset_req,
    input  wire logic                     i_low_voltage_detector,
    input  wire logic                     i_wake_irq,
    // cpu side
    input  wire srr_bus_cycle_t           i_bus_cycle,
    input  wire srr_option_register_one_t i_option_register_one,
    input  wire logic                     i_status_clear,
    // reset and mode outputs
    output logic                          o_internal_reset,
    output srr_reset_status_reg_t         o_reset_status_reg,
    output logic                          o_monitor_mode,
    output logic                          o_halted,
    // clocking outputs
    output logic                          o_clkgen_enable,
    output logic                          o_bus_clk_enable,
    output logic                          o_internal_bus_clk,
    output logic                          o_watchdog_tick,
    output logic [CNT_W-1:0]              o_recovery_count
);

    // ********************************************************
    // pin synchronisation and edges
    // ********************************************************
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] pins_s;
    logic              osc_s;
    logic              cgo_s;
    logic              por_s;
    logic              lvd_s;
    logic              wake_s;
    logic              osc_prev_q;
    logic              cgo_prev_q;
    logic              osc_fall;
    logic              cgo_rise;

    assign pins[PIN_OSC] = i_selected_osc_clock;
    assign pins[PIN_CGO] = i_clock_gen_output;
    assign pins[PIN_POR] = i_power_on_reset_req;
    assign pins[PIN_LVD] = i_low_voltage_detector;
    assign pins[PIN_WAK] = i_wake_irq;

    srr_sync #(
        .WIDTH   (SYNC_W)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (pins),
        .o_sync    (pins_s)
    );

    assign osc_s  = pins_s[PIN_OSC];
    assign cgo_s  = pins_s[PIN_CGO];
    assign por_s  = pins_s[PIN_POR];
    assign lvd_s  = pins_s[PIN_LVD];
    assign wake_s = pins_s[PIN_WAK];

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            osc_prev_q <= 1'b0;
            cgo_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_s;
            cgo_prev_q <= cgo_s;
        end
    end

    // oscillator is far slower than the reference, so edges are never lost
    assign osc_fall = osc_prev_q && !osc_s; // [R9]
    assign cgo_rise = !cgo_prev_q && cgo_s;

    // ********************************************************
    // reset sources
    // ********************************************************
    srr_state_t       state_q;
    logic             run;
    logic             lv_active;
    logic             hard_src;
    logic             ev_ilop;
    logic             ev_illegal_address_flag;
    logic             ev_erase;
    logic             ev_halt;
    logic             int_event;
    logic             monitor_q;
    logic             halt_short_q;
    logic [CNT_W-1:0] cnt;
    logic             wrap;
    logic             cnt_clear;
    logic             cnt_step;
    logic             stab_done;
    logic             vec_done;
    logic             halt_done;
    logic             bus_en;

    assign run = (state_q == ST_RUN);

    assign lv_active = lvd_s
                     && !i_option_register_one.lv_monitor_power_disable
                     && !i_option_register_one.lv_reset_disable; // [R6]

    assign hard_src = por_s || lv_active; // [R7] [R17]

    assign ev_ilop = run && i_bus_cycle.valid && i_bus_cycle.halt_instr
                   && !i_option_register_one.halt_enable; // [R1]

    // only opcode fetches qualify; data reads fall through harmlessly
    assign ev_illegal_address_flag = run && i_bus_cycle.valid && i_bus_cycle.opcode_fetch
                   && i_bus_cycle.unmapped; // [R2] [R3]

    // monitor vectors are not checked again, avoiding a reset loop
    assign ev_erase = run && i_bus_cycle.valid && i_bus_cycle.vector_fetch
                    && (i_bus_cycle.data == ERASED_BYTE)
                    && !monitor_q; // [R4]

    assign ev_halt = run && i_bus_cycle.valid && i_bus_cycle.halt_instr
                   && i_option_register_one.halt_enable;

    assign int_event = ev_ilop || ev_illegal_address_flag || ev_erase;

    // ********************************************************
    // recovery counter
    // ********************************************************
    assign cnt_clear = (state_q == ST_HOLD) || (state_q == ST_HALT)
                     || ev_halt; // [R12]
    assign cnt_step  = osc_fall; // [R14]

    srr_counter u_counter (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_clear   (cnt_clear),
        .i_step    (cnt_step),
        .o_count   (cnt),
        .o_wrap    (wrap)
    );

    assign stab_done = osc_fall && (cnt == STAB_LAST);   // [R8]
    assign vec_done  = osc_fall && (cnt == VECTOR_LAST); // [R8]
    assign halt_done = osc_fall
                     && (cnt == (halt_short_q ? HSHORT_LAST
                                              : HNORM_LAST)); // [R13]

    // ********************************************************
    // sequencer
    // ********************************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_HOLD;
        end else if (hard_src) begin
            state_q <= ST_HOLD; // [R7] [R17]
        end else begin
            case (state_q)
                ST_HOLD: begin
                    state_q <= ST_STAB;
                end
                ST_STAB: begin
                    if (stab_done) begin
                        state_q <= ST_VECTOR; // [R8] [R11]
                    end
                end
                ST_VECTOR: begin
                    if (vec_done) begin
                        state_q <= ST_RUN; // [R8]
                    end
                end
                ST_RUN: begin
                    if (int_event) begin
                        state_q <= ST_HOLD; // [R1] [R2] [R4]
                    end else if (ev_halt) begin
                        state_q <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (wake_s) begin
                        state_q <= ST_HALT_REC;
                    end
                end
                ST_HALT_REC: begin
                    if (halt_done) begin
                        state_q <= ST_RUN; // [R11] [R13]
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                end
            endcase
        end
    end

    // short recovery choice is sampled at the wake event only
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            halt_short_q <= 1'b0;
        end else if (state_q == ST_HALT && wake_s) begin
            halt_short_q <= i_option_register_one.short_recovery_select; // [R13]
        end
    end

    // ********************************************************
    // status flags and monitor mode
    // ********************************************************
    srr_reset_status_reg_t status_q;

    // a flag that sets in the clearing cycle survives the clear
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            status_q <= STATUS_POR_VALUE;
        end else if (por_s) begin
            status_q <= STATUS_POR_VALUE;
        end else begin
            status_q.por <= status_q.por && !i_status_clear;
            status_q.illegal_opcode <= ev_ilop
                || (status_q.illegal_opcode && !i_status_clear); // [R1]
            status_q.illegal_address_flag <= ev_illegal_address_flag
                || (status_q.illegal_address_flag && !i_status_clear); // [R2]
            status_q.erased_vector_reset <= ev_erase
                || (status_q.erased_vector_reset && !i_status_clear); // [R4]
            status_q.low_voltage <= lv_active
                || (status_q.low_voltage && !i_status_clear); // [R6]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            monitor_q <= 1'b0;
        end else if (por_s) begin
            monitor_q <= 1'b0;
        end else if (ev_erase) begin
            monitor_q <= 1'b1; // [R5]
        end
    end

    // ********************************************************
    // clock generator and bus clock
    // ********************************************************
    logic clkgen_en_q;
    logic bus_clk_q;
    logic tick_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clkgen_en_q <= 1'b0;
        end else begin
            clkgen_en_q <= !por_s; // [R15]
        end
    end

    assign bus_en = (state_q == ST_VECTOR) || run; // [R11]

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_clk_q <= 1'b0;
        end else if (!bus_en) begin
            bus_clk_q <= 1'b0;
        end else if (cgo_rise) begin
            bus_clk_q <= !bus_clk_q; // [R16]
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= wrap; // [R10]
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign o_internal_reset   = (state_q == ST_HOLD) || (state_q == ST_STAB)
                              || (state_q == ST_VECTOR); // [R17]
    assign o_reset_status_reg = status_q;
    assign o_monitor_mode     = monitor_q;
    assign o_halted           = (state_q == ST_HALT)
                              || (state_q == ST_HALT_REC);
    assign o_clkgen_enable    = clkgen_en_q;
    assign o_bus_clk_enable   = bus_en;
    assign o_internal_bus_clk = bus_clk_q;
    assign o_watchdog_tick    = tick_q;
    assign o_recovery_count   = cnt;

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_halt_illegal_op: assert property ( // [R1]
        ev_ilop && !hard_src |=> o_internal_reset
            && o_reset_status_reg.illegal_opcode)
        else $error("halt with halt disabled gave no reset");

    a_illegal_address_flag_reset: assert property ( // [R2]
        ev_illegal_address_flag && !hard_src |=> o_internal_reset
            && o_reset_status_reg.illegal_address_flag)
        else $error("unmapped opcode fetch gave no reset");

    a_data_no_reset: assert property ( // [R3]
        run && !hard_src && !ev_ilop && !ev_erase && !ev_halt
            && i_bus_cycle.valid && !i_bus_cycle.opcode_fetch
            |=> !o_internal_reset)
        else $error("data read caused a reset");

    a_erased_vector: assert property ( // [R4]
        ev_erase && !hard_src |=> o_internal_reset
            && o_reset_status_reg.erased_vector_reset)
        else $error("erased vector gave no reset");

    a_monitor_entry: assert property ( // [R5]
        $fell(o_internal_reset) && o_reset_status_reg.erased_vector_reset
            && !$past(i_status_clear) |-> o_monitor_mode)
        else $error("no monitor mode after erased vector reset");

    a_lv_flag_set: assert property ( // [R6]
        lv_active && !por_s |=> o_reset_status_reg.low_voltage
            && o_internal_reset)
        else $error("low voltage did not flag and reset");

    a_lv_hold: assert property ( // [R7]
        lv_active ##1 lv_active |=> o_internal_reset
            && o_recovery_count == CNT_ZERO)
        else $error("recovery counted while low voltage held");

    a_stab_to_vector: assert property ( // [R8]
        state_q == ST_STAB && stab_done && !hard_src
            |=> state_q == ST_VECTOR && o_internal_reset && o_bus_clk_enable)
        else $error("stabilisation count end mishandled");

    a_vector_release: assert property ( // [R8]
        state_q == ST_VECTOR && vec_done && !hard_src
            |=> !o_internal_reset)
        else $error("cpu not released after vector delay");

    a_counter_step: assert property ( // [R9]
        state_q == ST_STAB && osc_fall && !hard_src
            |=> o_recovery_count == $past(o_recovery_count) + CNT_ONE)
        else $error("counter did not step on oscillator fall");

    a_wd_tick: assert property ( // [R10]
        wrap |=> o_watchdog_tick && o_recovery_count == CNT_ZERO)
        else $error("overflow gave no watchdog tick");

    a_halt_clear: assert property ( // [R12]
        ev_halt && !hard_src && !int_event |=> o_halted && cnt == CNT_ZERO)
        else $error("halt did not clear the counter");

    a_short_recovery: assert property ( // [R13]
        state_q == ST_HALT_REC && halt_short_q && osc_fall
            && cnt == HSHORT_LAST && !hard_src |=> run)
        else $error("short halt recovery not taken");

    a_clkgen_enable: assert property ( // [R15]
        $fell(por_s) |=> o_clkgen_enable)
        else $error("clock generator not enabled after power-on");

    a_bus_half_rate: assert property ( // [R16]
        bus_en |=> ((o_internal_bus_clk != $past(o_internal_bus_clk))
            == $past(cgo_rise)))
        else $error("bus clock not half the generator rate");

    a_src_reset: assert property ( // [R17]
        hard_src |=> o_internal_reset)
        else $error("active reset source left reset low");

    c_lv_recovery: cover property (
        state_q == ST_VECTOR ##1 run);
    c_halt_wake: cover property (
        state_q == ST_HALT_REC ##1 run);
    c_erased_entry: cover property (
        ev_erase ##[1:300] o_monitor_mode);

endmodule

// *** verif/srr_far_model.sv ***
// oscillator, clock generator and detector model for the bench
module srr_far_model (
    // clock
    input  wire logic i_ref_clk,
    // bench requests
    input  wire logic i_por_on,
    input  wire logic i_lvd_on,
    input  wire logic i_wake_on,
    // pins
    output logic      o_osc,
    output logic      o_cgo,
    output logic      o_por,
    output logic      o_lvd,
    output logic      o_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // free-running sources and detector levels
    // ****************************************
    logic [2:0] ph_q = 3'h0;
    initial begin
        {o_osc, o_cgo, o_por, o_lvd, o_wake} = 5'h04;
    end
    // osc: 2 ref cycles high, 2 low, the fastest the syncs allow
    always @(posedge i_ref_clk) begin
        ph_q <= ph_q + 3'h1;
        o_osc <= ph_q[1];
        o_cgo <= ph_q[2];
        o_por <= i_por_on;
        o_lvd <= i_lvd_on;
        o_wake <= i_wake_on;
    end
endmodule

// *** verif/system_reset_and_recovery_counter_bench.sv ***
// bench of the reset and recovery block against a fall-count model
module system_reset_and_recovery_counter_bench
    import srr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // stimulus, design and model state
    // ****************************************
    logic clk = 1'b0, rst_b = 1'b0, por_on = 1'b1, lvd_on = 1'b0;
    logic wake_on = 1'b0, clr = 1'b0, osc_p = 1'b0;
    logic osc, cgo, por, lvd, wake, rst, mon, hlt, cge, bce, bclk, tick;
    srr_bus_cycle_t           bc  = '0;
    srr_option_register_one_t opt = 4'h8;
    srr_reset_status_reg_t    st, exp_st;
    logic [CNT_W-1:0]         cnt;
    int n_fail = 0, cmp_count = 0, n_bclk = 0, seed = 32'hfc4d;
    int n_stab, n_vec, n_halt, n_tick;
    always #10 clk = ~clk;
    srr_far_model u_srr_far_model (.i_ref_clk(clk), .i_por_on(por_on),
        .i_lvd_on(lvd_on), .i_wake_on(wake_on), .o_osc(osc), .o_cgo(cgo),
        .o_por(por), .o_lvd(lvd), .o_wake(wake));
    srr_top u_srr_top (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_selected_osc_clock(osc), .i_clock_gen_output(cgo),
        .i_power_on_reset_req(por), .i_low_voltage_detector(lvd),
        .i_wake_irq(wake), .i_bus_cycle(bc), .i_option_register_one(opt),
        .i_status_clear(clr), .o_internal_reset(rst),
        .o_reset_status_reg(st), .o_monitor_mode(mon), .o_halted(hlt),
        .o_clkgen_enable(cge), .o_bus_clk_enable(bce),
        .o_internal_bus_clk(bclk), .o_watchdog_tick(tick),
        .o_recovery_count(cnt));
    // model: osc falls per phase, seen at the pins
    always @(posedge clk) begin
        osc_p <= osc;
        if (tick) n_tick++;
        if (osc_p && !osc) begin
            if (rst && !bce && !por && !lvd) n_stab++;
            if (rst && bce) n_vec++;
            if (hlt && wake) n_halt++;
        end
    end
    always @(posedge bclk) n_bclk++;
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string nm, input logic [11:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // falls straddle the sync delay, so allow two either way
    task automatic near(input string nm, input int got, exp);
        check(nm, 12'(got >= exp - 2 && got <= exp + 2), 12'h001);
    endtask
    task automatic cyc(input logic [3:0] k, input logic [7:0] d);
        @(posedge clk);
        bc <= {1'b1, k, d};
        @(posedge clk);
        bc <= '0;
        @(posedge clk);
        #1;
    endtask
    task automatic recover();
        n_stab = 0;
        n_vec = 0;
        n_tick = 0;
        for (int i = 0; i < 20000 && rst !== 1'b0; i++) @(posedge clk);
        #1;
        near("stab", n_stab, LV_RECOVERY_CYC);
        near("vector", n_vec, VECTOR_DELAY_CYC);
        check("wd_tick", 12'(n_tick), 12'h001);
        check("rst_off", rst, 1'b0);
        @(posedge clk);
    endtask
    task automatic hit(input logic [3:0] k, input logic [7:0] d);
        cyc(k, d);
        check("rst_on", rst, 1'b1);
        check("status", 12'(st), 12'(exp_st));
        recover();
    endtask
    task automatic clear_st();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        exp_st = STATUS_ZERO;
    endtask
    task automatic run_chk();
        logic [CNT_W-1:0] c0;
        int nb;
        c0 = cnt;
        nb = n_bclk;
        repeat (64) @(posedge clk);
        near("count", int'(12'(cnt - c0)), 16);
        near("bus_clk", n_bclk - nb, 4);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        exp_st = STATUS_POR_VALUE;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (20) @(posedge clk);
        check("cge_por", cge, 1'b0);
        por_on <= 1'b0;
        recover();
        check("cge", cge, 1'b1);
        check("status", 12'(st), 12'(exp_st));
        run_chk();
        clear_st();
        repeat (16) cyc({1'b0, 1'($random(seed)), 2'b00}, 8'($random(seed)));
        check("read_unmapped", rst, 1'b0);
        exp_st.illegal_address_flag = 1'b1;
        hit(4'b1100, 8'($random(seed)));
        clear_st();
        opt.halt_enable <= 1'b0;
        exp_st.illegal_opcode = 1'b1;
        hit(4'b1010, 8'h8e);
        clear_st();
        exp_st.erased_vector_reset = 1'b1;
        hit(4'b0001, ERASED_BYTE);
        check("monitor", mon, 1'b1);
        cyc(4'b0001, ERASED_BYTE);
        check("mon_no_rst", rst, 1'b0);
        clear_st();
        for (int b = 1; b < 3; b++) begin
            opt[b] <= 1'b1;
            lvd_on <= 1'b1;
            repeat (20) @(posedge clk);
            check("lv_masked", rst, 1'b0);
            lvd_on <= 1'b0;
            repeat (8) @(posedge clk);
            opt[b] <= 1'b0;
        end
        exp_st.low_voltage = 1'b1;
        lvd_on <= 1'b1;
        repeat (500) @(posedge clk);
        check("lv_rst", rst, 1'b1);
        check("lv_bus", bce, 1'b0);
        check("status", 12'(st), 12'(exp_st));
        lvd_on <= 1'b0;
        recover();
        opt <= 4'h9;
        cyc(4'b1010, 8'h8e);
        check("halted", hlt, 1'b1);
        check("hcount", cnt, CNT_ZERO);
        check("hbus", bce, 1'b0);
        repeat (100) @(posedge clk);
        n_halt = 0;
        wake_on <= 1'b1;
        for (int i = 0; i < 400 && hlt !== 1'b0; i++) @(posedge clk);
        wake_on <= 1'b0;
        #1;
        near("halt_rec", n_halt, HALT_SHORT_CYC);
        check("no_rst", rst, 1'b0);
        run_chk();
        complete_run();
    end
endmodule
